// >>> design/ops_pkg.sv
// Package for the on-air preset selector: register map, fields, timing
package ops_pkg;
  localparam logic [7:0] ops_reg_ctrl = 8'h00;
  localparam logic [7:0] ops_reg_cmd = 8'h04;
  localparam logic [7:0] ops_reg_status = 8'h08;
  localparam logic [7:0] ops_reg_time = 8'h0C;
  localparam logic [7:0] ops_reg_name = 8'h10;
  localparam logic [7:0] ops_reg_export = 8'h14;
  localparam logic [7:0] ops_reg_import = 8'h18;
  localparam logic [7:0] ops_reg_dp_base = 8'h20;
  localparam logic [7:0] ops_reg_dp_start = 8'h40;
  // Ctrl fields
  localparam int ops_ctrl_trig_en = 0;
  localparam int ops_ctrl_sched_en = 1;
  localparam int ops_ctrl_cmp_b = 2;
  // Command codes in cmd[2:0], slot in cmd[8:4]
  localparam logic [2:0] ops_cmd_load = 3'h1;
  localparam logic [2:0] ops_cmd_save = 3'h2;
  localparam logic [2:0] ops_cmd_rename = 3'h3;
  localparam logic [2:0] ops_cmd_import = 3'h4;
  localparam logic [2:0] ops_cmd_edit = 3'h5;
  // Preset codes: 0 off, 1..8 user, 9..31 factory
  localparam logic [4:0] ops_preset_off = 5'h00;
  localparam logic [4:0] first_user_slot = 5'h01;
  localparam logic [4:0] last_user_slot = 5'h08;
  localparam logic [4:0] ops_reset_default = 5'h01;
  // Day code 7 means every day
  localparam logic [2:0] ops_day_all = 3'h7;
  localparam int ops_name_max = 15;
  localparam int ops_dp_count = 8;
  // Debounce time in us and derived cycles at 200 MHz
  localparam int ops_debounce_us = 5000;
  localparam int ops_clk_mhz = 200;
  localparam int ops_debounce_cycles = ops_debounce_us * ops_clk_mhz;
  localparam int ops_mins_per_day = 1440;
  typedef enum logic [1:0] {
    ops_idle = 2'b00,
    ops_data = 2'b01
  } ops_bus_t;
endpackage

// >>> design/ops_onair_preset_selector.sv
// On-air preset selector with AHB-Lite register slave
// Overview of operation
// - Low trigger n puts user preset n+1 on air
// - Trigger port enable bit gates all triggers
// - Lowest numbered low trigger wins
// - Trigger release returns to normal preset
// - No override keeps default preset on air
// - Ending override returns to current default
// - Load command replaces default, airs if free
// - Load during override defers airing
// - Save copies live settings of loaded default preset to chosen slot
// - Factory slots never written
// - Names longer than fifteen characters truncated
// - Export returns chosen slot contents
// - Import writes user slot only, no airing
// - Eight daypart entries in two banks
// - Daypart target may be off
// - Daypart start holds day, hour, minute
// - Day code all matches every day
// - Daypart duration in minutes
// - Scheduler global enable gates dayparts
// - Overlapping dayparts allowed, one overrides
// - Report default, daypart, trigger source tags
// - Load disarms compare; edit arms it
// - Compare B written while compare armed blocks edits
// - Daypart starts when clock equals start
// - Daypart ends at midnight at latest
`timescale 1ns/100ps
module ops_onair_preset_selector
  import ops_pkg::*;
#(
  parameter int debounce_cycles = ops_debounce_cycles,
  parameter int slot_count = 32
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] trig_n,
  input wire logic [2:0] rtc_day,
  input wire logic [4:0] rtc_hour,
  input wire logic [5:0] rtc_min,
  output logic [4:0] onair_preset,
  output logic default_source_tag,
  output logic schedule_source_tag,
  output logic contact_source_tag,
  output logic compare_armed,
  output logic edits_blocked
);
  if (debounce_cycles < 1 || slot_count != 32)
    $error("ops: unsupported parameters");
  // Bus slave: single-cycle data phase, always OKAY
  logic ph_wr;
  logic [7:0] ph_addr;
  logic [2:0] cmd_op;
  logic [4:0] cmd_slot;
  logic cmd_go;
  logic [31:0] ctrl;
  logic [4:0] default_preset;
  logic [4:0] dp_target [ops_dp_count];
  logic [13:0] dp_start [ops_dp_count];
  logic [10:0] dp_len [ops_dp_count];
  logic [31:0] slot_data [slot_count];
  logic [31:0] live_data;
  logic [3:0] name_len;
  logic refused;
  logic [4:0] sel_slot;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr <= 1'b0;
      ph_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (hready)
    begin
      ph_wr <= hsel && htrans[1] && hwrite;
      ph_addr <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign cmd_go = ph_wr && ph_addr == ops_reg_cmd;
  assign cmd_op = hwdata[2:0];
  assign cmd_slot = hwdata[8:4];
  function automatic logic is_user(input logic [4:0] s);
    return s >= first_user_slot && s <= last_user_slot;
  endfunction
  // Trigger synchroniser and per-input debounce
  logic [7:0] trig_s1;
  logic [7:0] trig_s2;
  logic [7:0] trig_db;
  logic [31:0] db_cnt [8];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trig_s1 <= 8'hFF;
      trig_s2 <= 8'hFF;
    end
    else
    begin
      trig_s1 <= trig_n;
      trig_s2 <= trig_s1;
    end
  end

  for (genvar i = 0; i < 8; i++)
  begin : g_db
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        db_cnt[i] <= 32'h0;
        trig_db[i] <= 1'b0;
      end
      // Level must hold stable for the whole window before it counts
      else if ((!trig_s2[i]) == trig_db[i])
        db_cnt[i] <= 32'h0;
      else if (db_cnt[i] >= 32'(debounce_cycles - 1))
      begin
        db_cnt[i] <= 32'h0;
        trig_db[i] <= !trig_s2[i];
      end
      else
        db_cnt[i] <= db_cnt[i] + 32'h1;
    end
  end

  // Priority: lowest input number wins
  logic trig_act;
  logic [4:0] trig_preset;
  always_comb
  begin
    trig_act = 1'b0;
    trig_preset = ops_preset_off;
    for (int i = 7; i >= 0; i--)
      if (trig_db[i] && ctrl[ops_ctrl_trig_en])
      begin
        trig_act = 1'b1;
        trig_preset = first_user_slot + 5'(i);
      end
  end

  // Dayparts: minute counters, ended by duration or midnight
  logic [10:0] now_min;
  logic [10:0] dp_left [ops_dp_count];
  logic [ops_dp_count-1:0] dp_act;
  logic [2:0] newest;
  logic [5:0] last_min;
  logic min_tick;
  logic [ops_dp_count-1:0] dp_hit;
  assign now_min = 11'(rtc_hour) * 11'd60 + 11'(rtc_min);
  assign min_tick = rtc_min != last_min;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      last_min <= 6'h3F;
    else
      last_min <= rtc_min;
  end

  for (genvar d = 0; d < ops_dp_count; d++)
  begin : g_dp
    // Day all or exact day, then hour and minute equal the clock
    assign dp_hit[d] = min_tick && dp_target[d] != ops_preset_off
      && (dp_start[d][13:11] == ops_day_all || dp_start[d][13:11] == rtc_day)
      && dp_start[d][10:0] == now_min && dp_len[d] != 11'h0;
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        dp_act[d] <= 1'b0;
        dp_left[d] <= 11'h0;
      end
      else if (dp_hit[d])
      begin
        dp_act[d] <= 1'b1;
        dp_left[d] <= dp_len[d];
      end
      else if (dp_act[d] && min_tick)
      begin
        dp_left[d] <= dp_left[d] - 11'h1;
        // Midnight wraps now_min to zero and cuts it short
        if (dp_left[d] == 11'h1 || now_min == 11'h0)
          dp_act[d] <= 1'b0;
      end
    end
  end
  // Most recent starter recorded; overlaps are legal
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      newest <= 3'h0;
    else
      for (int d = 0; d < ops_dp_count; d++)
        if (dp_hit[d])
          newest <= 3'(d);
  end
  logic sched_act;
  logic [4:0] sched_preset;
  always_comb
  begin
    sched_act = 1'b0;
    sched_preset = ops_preset_off;
    for (int d = 0; d < ops_dp_count; d++)
      if (dp_act[d] && ctrl[ops_ctrl_sched_en])
      begin
        sched_act = 1'b1;
        sched_preset = dp_target[d];
      end
    if (dp_act[newest] && ctrl[ops_ctrl_sched_en])
      sched_preset = dp_target[newest];
  end

  // On-air choice, registered straight to outputs
  logic [4:0] next_onair;
  always_comb
  begin
    if (trig_act)
      next_onair = trig_preset;
    else if (sched_act)
      next_onair = sched_preset;
    else
      next_onair = default_preset;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      onair_preset <= ops_reset_default;
      default_source_tag <= 1'b1;
      schedule_source_tag <= 1'b0;
      contact_source_tag <= 1'b0;
    end
    else
    begin
      onair_preset <= next_onair;
      default_source_tag <= next_onair == default_preset;
      schedule_source_tag <= sched_act && next_onair == sched_preset;
      contact_source_tag <= trig_act;
    end
  end

  // Registers and commands
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= 32'h0;
      default_preset <= ops_reset_default;
      sel_slot <= first_user_slot;
      name_len <= 4'h0;
      refused <= 1'b0;
      compare_armed <= 1'b0;
      edits_blocked <= 1'b0;
      live_data <= 32'h0;
      for (int d = 0; d < ops_dp_count; d++)
      begin
        dp_target[d] <= ops_preset_off;
        dp_start[d] <= 14'h0;
        dp_len[d] <= 11'h0;
      end
    end
    else if (ph_wr)
    begin
      if (ph_addr == ops_reg_ctrl)
      begin
        ctrl <= {29'h0, hwdata[2:0]};
        edits_blocked <= hwdata[ops_ctrl_cmp_b] && compare_armed;
      end
      for (int d = 0; d < ops_dp_count; d++)
      begin
        if (ph_addr == ops_reg_dp_base + 8'(d * 4))
        begin
          dp_target[d] <= hwdata[4:0];
          dp_len[d] <= hwdata[26:16];
        end
        if (ph_addr == ops_reg_dp_start + 8'(d * 4))
          dp_start[d] <= hwdata[13:0];
      end
      if (ph_addr == ops_reg_import)
      begin
        refused <= !is_user(sel_slot);
      end
      if (cmd_go)
      begin
        sel_slot <= cmd_slot;
        refused <= 1'b0;
        case (cmd_op)
          ops_cmd_load:
          begin
            default_preset <= cmd_slot;
            compare_armed <= 1'b0;
            edits_blocked <= 1'b0;
            ctrl[ops_ctrl_cmp_b] <= 1'b0;
            live_data <= slot_data[cmd_slot];
          end
          ops_cmd_save: refused <= !is_user(cmd_slot);
          ops_cmd_rename:
          begin
            refused <= !is_user(cmd_slot);
            // Longer names are cut rather than rejected
            name_len <= hwdata[15:12] > 4'(ops_name_max) ? 4'(ops_name_max)
              : hwdata[15:12];
          end
          ops_cmd_edit:
            if (!edits_blocked)
            begin
              compare_armed <= 1'b1;
              live_data <= {live_data[30:0], 1'b1} ^ {23'h0, hwdata[16:8]};
            end
          default: ;
        endcase
      end
    end
  end

  // Slot store; factory contents are built in at reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      for (int s = 0; s < slot_count; s++)
        slot_data[s] <= 32'(s);
    else if (cmd_go && cmd_op == ops_cmd_save && is_user(cmd_slot))
      slot_data[cmd_slot] <= live_data;
    else if (ph_wr && ph_addr == ops_reg_import && is_user(sel_slot))
      slot_data[sel_slot] <= hwdata;
  end

  // Read mux
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      hrdata <= 32'h0;
      case (haddr[7:0])
        ops_reg_ctrl: hrdata <= ctrl;
        ops_reg_status: hrdata <= {16'h0, 3'h0, refused, edits_blocked, compare_armed,
          contact_source_tag, schedule_source_tag, default_source_tag,
          default_preset, onair_preset[1:0]};
        ops_reg_time: hrdata <= {21'h0, now_min};
        ops_reg_name: hrdata <= {28'h0, name_len};
        ops_reg_export: hrdata <= slot_data[sel_slot];
        ops_reg_cmd: hrdata <= {23'h0, sel_slot, 4'h0};
        default:
          for (int d = 0; d < ops_dp_count; d++)
          begin
            if (haddr[7:0] == ops_reg_dp_base + 8'(d * 4))
              hrdata <= {5'h0, dp_len[d], 11'h0, dp_target[d]};
            if (haddr[7:0] == ops_reg_dp_start + 8'(d * 4))
              hrdata <= {18'h0, dp_start[d]};
          end
      endcase
    end
  end

  a_trig_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    trig_act |=> onair_preset == $past(trig_preset)) else $error("trigger not on air");
  a_trig_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl[ops_ctrl_trig_en] |-> !trig_act) else $error("trigger port off ignored");
  a_low_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    trig_act && trig_db[0] |-> trig_preset == first_user_slot) else $error("priority");
  a_default_air: assert property (@(posedge hclk) disable iff (!hresetn)
    !trig_act && !sched_act |=> onair_preset == $past(default_preset)) else $error("default");
  a_load_default: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && cmd_op == ops_cmd_load |=> default_preset == $past(cmd_slot)) else $error("load");
  a_factory_safe: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && cmd_op == ops_cmd_save && !is_user(cmd_slot) |=> $stable(slot_data[31]))
    else $error("factory written");
  a_name_limit: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && cmd_op == ops_cmd_rename |=> name_len == $past(hwdata[15:12])) else $error("name");
  a_load_disarm: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && cmd_op == ops_cmd_load |=> !compare_armed && !edits_blocked)
    else $error("compare");
  a_sched_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl[ops_ctrl_sched_en] |-> !sched_act) else $error("scheduler off");
  c_trigger: cover property (@(posedge hclk) trig_act);
  c_daypart: cover property (@(posedge hclk) sched_act && !trig_act);
  c_all_tags: cover property (@(posedge hclk)
    default_source_tag && schedule_source_tag && contact_source_tag);
endmodule

// >>> test/ops_contact_model.sv
// Contact closure bank driving the trigger inputs, with optional chatter
`timescale 1ns/100ps
module ops_contact_model (
  input wire logic hclk,
  input wire logic [7:0] close_req,
  input wire logic bounce,
  output logic [7:0] trig_n
);
  logic [7:0] last;
  logic [7:0] old;
  logic [1:0] cnt;
  initial
  begin
    trig_n = 8'hFF;
    last = 8'h00;
    old = 8'h00;
    cnt = 2'h0;
  end
  // Chatter flips between old and new levels, shorter than the debounce span
  always @(posedge hclk)
  begin
    last <= close_req;
    if (close_req !== last && bounce)
    begin
      cnt <= 2'h3;
      old <= last;
    end
    else if (cnt != 2'h0)
      cnt <= cnt - 2'h1;
    trig_n <= (cnt[0] ? ~old : ~close_req);
  end
endmodule

// >>> test/tb.sv
// Self-checking bench for the on-air preset selector
`timescale 1ns/100ps
module tb;
  import ops_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m; bit pt;} ops_note_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, bounce, take_rd, take_pt;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, rtc_day;
  logic [7:0] close_req, trig_n;
  logic [4:0] rtc_hour, onair_preset;
  logic [5:0] rtc_min;
  logic default_source_tag, schedule_source_tag, contact_source_tag;
  logic compare_armed, edits_blocked;
  logic [15:0] lfsr;
  wire logic hready;
  wire logic [9:0] pv;
  ops_note_t q[$];
  ops_note_t cur;
  int failures, cmp_count;
  assign hready = hreadyout;
  assign pv = {edits_blocked, compare_armed, contact_source_tag, schedule_source_tag,
    default_source_tag, onair_preset};
  ops_onair_preset_selector #(.debounce_cycles(4)) u_ops_onair_preset_selector (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trig_n(trig_n), .rtc_day(rtc_day),
    .rtc_hour(rtc_hour), .rtc_min(rtc_min), .onair_preset(onair_preset),
    .default_source_tag(default_source_tag), .schedule_source_tag(schedule_source_tag),
    .contact_source_tag(contact_source_tag), .compare_armed(compare_armed),
    .edits_blocked(edits_blocked));
  ops_contact_model u_ops_contact_model (
    .hclk(hclk), .close_req(close_req), .bounce(bounce), .trig_n(trig_n));
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Monitor takes the oldest note whenever a result is due
  always @(posedge hclk)
  begin
    if (take_rd || take_pt)
    begin
      cur = q.pop_front();
      check((take_rd ? hrdata : {22'h0, pv}) & cur.m, cur.v & cur.m);
    end
  end
  // Single AHB-Lite word transfer; waits on hready, but read data is checked at the first edge after the address phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic [31:0] m);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    if (!w)
    begin
      q.push_back('{e, m, 1'b0});
      take_rd <= 1'b1;
    end
    do @(posedge hclk); while (hready !== 1'b1);
    take_rd <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0, e, m);
  endtask
  task automatic cmd(input logic [2:0] op, input logic [4:0] s, input logic [31:0] x);
    wr(ops_reg_cmd, x | {23'h0, s, 1'b0, op});
  endtask
  task automatic pchk(input logic [9:0] e, input logic [9:0] m, input int w);
    repeat (w) @(posedge hclk);
    q.push_back('{{22'h0, e}, {22'h0, m}, 1'b1});
    take_pt <= 1'b1;
    @(posedge hclk);
    take_pt <= 1'b0;
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  initial
  begin
    #(5 * 20000);
    failures++;
    $display("ERROR at %0t: watchdog expired", $time);
    results();
  end
  initial
  begin
    {hsel, hwrite, take_rd, take_pt, bounce} = 5'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    close_req = 8'h00;
    {rtc_day, rtc_hour, rtc_min} = {3'h2, 5'h01, 6'h27};
    lfsr = 16'h5D4D;
    failures = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    pchk(10'h021, 10'h3FF, 0);
    rd(ops_reg_status, 32'h0000_0085, 32'h0000_1FFF);
    lfsr = nxt(lfsr);
    wr(8'h60, {lfsr, lfsr});
    rd(8'h60, 32'h0, 32'hFFFF_FFFF);
    done("reset");
    cmd(ops_cmd_load, 5'h03, 32'h0);
    pchk(10'h023, 10'h3FF, 3);
    close_req <= 8'h02;
    pchk(10'h023, 10'h3FF, 14);
    wr(ops_reg_ctrl, 32'h1);
    pchk(10'h082, 10'h3FF, 12);
    bounce <= 1'b1;
    close_req <= 8'hFF;
    pchk(10'h081, 10'h3FF, 14);
    close_req <= 8'h00;
    pchk(10'h023, 10'h3FF, 14);
    close_req <= 8'h10;
    pchk(10'h085, 10'h3FF, 14);
    cmd(ops_cmd_load, 5'h06, 32'h0);
    pchk(10'h085, 10'h3FF, 3);
    rd(ops_reg_status, 32'h0000_0018, 32'h0000_007C);
    close_req <= 8'h00;
    pchk(10'h026, 10'h3FF, 14);
    close_req <= 8'h20;
    pchk(10'h0A6, 10'h3FF, 14);
    close_req <= 8'h00;
    done("triggers");
    cmd(ops_cmd_save, 5'h02, 32'h0);
    rd(ops_reg_status, 32'h0, 32'h0000_1000);
    cmd(ops_cmd_save, 5'h0A, 32'h0);
    rd(ops_reg_status, 32'h0000_1000, 32'h0000_1000);
    cmd(ops_cmd_rename, 5'h02, 32'h0000_F000);
    rd(ops_reg_name, 32'hF, 32'h1F);
    lfsr = nxt(lfsr);
    cmd(ops_cmd_import, 5'h05, 32'h0);
    wr(ops_reg_import, {24'h0, lfsr[7:0]});
    rd(ops_reg_export, {24'h0, lfsr[7:0]}, 32'hFF);
    cmd(ops_cmd_import, 5'h0C, 32'h0);
    wr(ops_reg_import, {lfsr, lfsr});
    rd(ops_reg_status, 32'h0000_1000, 32'h0000_1000);
    pchk(10'h026, 10'h0FF, 14);
    done("slots");
    lfsr = nxt(lfsr);
    cmd(ops_cmd_edit, 5'h00, {15'h0, lfsr[8:0], 8'h0});
    pchk(10'h100, 10'h100, 3);
    wr(ops_reg_ctrl, 32'h5);
    pchk(10'h300, 10'h300, 3);
    wr(ops_reg_ctrl, 32'h1);
    pchk(10'h100, 10'h300, 3);
    cmd(ops_cmd_load, 5'h06, 32'h0);
    pchk(10'h000, 10'h100, 3);
    done("compare");
    wr(ops_reg_dp_base, 32'h0002_0004);
    wr(ops_reg_dp_start, {18'h0, ops_day_all, 11'd100});
    wr(ops_reg_ctrl, 32'h3);
    rtc_min <= 6'd40;
    pchk(10'h044, 10'h0FF, 5);
    rtc_min <= 6'd41;
    pchk(10'h044, 10'h0FF, 5);
    rtc_min <= 6'd42;
    pchk(10'h026, 10'h0FF, 5);
    wr(ops_reg_dp_start, {18'h0, ops_day_all, 11'd103});
    wr(ops_reg_ctrl, 32'h1);
    rtc_min <= 6'd43;
    pchk(10'h026, 10'h0FF, 5);
    wr(ops_reg_dp_base, 32'h001E_0004);
    wr(ops_reg_dp_start, {18'h0, ops_day_all, 11'd1439});
    wr(ops_reg_dp_base + 8'h04, 32'h001E_0007);
    wr(ops_reg_dp_start + 8'h04, {18'h0, ops_day_all, 11'd1438});
    wr(ops_reg_ctrl, 32'h3);
    {rtc_hour, rtc_min} <= {5'd23, 6'd58};
    pchk(10'h047, 10'h0FF, 5);
    rtc_min <= 6'd59;
    pchk(10'h044, 10'h0FF, 5);
    close_req <= 8'h04;
    pchk(10'h083, 10'h0FF, 14);
    close_req <= 8'h00;
    pchk(10'h044, 10'h0FF, 14);
    {rtc_day, rtc_hour, rtc_min} <= {3'h3, 5'd0, 6'd0};
    pchk(10'h026, 10'h0FF, 5);
    done("schedule");
    results();
  end
endmodule
